// file: adcts_top.sv
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// R1 - writing 1 to start bit converts the selected channel
// R2 - each conversion end loads both result registers and pulses interrupt
// R3 - continuous mode starts the next conversion at once
// R4 - single mode clears start bit after one conversion, then waits
// R5 - software mode: writing 1 while converting aborts and restarts
// R6 - channel rewrite aborts and restarts, except timer single mode
// R7 - timer single mode: new channel applies at next start
// R8 - software mode: writing 0 stops at once, result kept
// R9 - timer enable bit places converter in timer trigger mode
// R10 - timer trigger sets start bit and starts conversion
// R11 - trigger during conversion aborts and restarts it
// R12 - timer continuous: writing 0 stops and waits for next trigger
// R13 - clearing timer enable with start bit 0 selects software mode
// R14 - trigger pulses spaced at least one conversion time apart
// R15 - software waits 1 us after comparator enable before starting
// R16 - software discards first result if settling was skipped
// R17 - low voltage modes: booster on, wait 10 us, then comparator
// R18 - trigger mode register: source select bit 0, timer enable bit 7
// R19 - mode register: conversion time bits 5..1, single select bit 6
// R20 - channel select register holds channel in bits 3..0
// R21 - mode register bit 0 enables the voltage comparator
// R22 - software clears start bit, comparator, then timer enable
// R23 - reset clears wide and narrow result registers to zero
// R24 - a coinciding result read returns the old value first
// R25 - a coinciding mode, channel or port write drops the result
// R26 - narrow result is upper eight bits of the 12-bit result
module adcts_top
  import adcts_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  input wire logic [TRIG_W-1:0] timer_trig,
  input wire logic comp_in,
  output logic conv_end_irq,
  output logic [CHAN_W-1:0] chan_active,
  output logic sample_hold,
  output logic [RES_W-1:0] tap_code,
  output logic comparator_enable,
  output logic booster_enable,
  output logic ref_source_sel,
  output logic [CTS_W-1:0] conv_time_sel,
  output logic [PORT_CFG_W-1:0] port_analog_cfg
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adcts_sar_if sar_bus ();

  logic conv_start_bit_reg;
  logic single_continuous_sel_reg;
  logic [CTS_W-1:0] conv_time_sel_reg;
  logic comparator_enable_reg;
  logic timer_trig_enable_reg;
  logic trig_source_sel_reg;
  logic [CHAN_W-1:0] channel_field_reg;
  logic [CHAN_W-1:0] chan_active_reg;
  logic [PORT_CFG_W-1:0] port_analog_cfg_reg;
  logic ref_source_sel_reg;
  logic booster_enable_reg;
  logic [WIDE_W-1:0] result_wide_reg;
  logic [DATA_W-1:0] result_narrow_reg;
  logic conv_end_irq_reg;
  logic [DATA_W-1:0] rdata_reg;

  logic wr_mode;
  logic wr_trig;
  logic wr_chan;
  logic wr_port;
  logic wr_ref;
  logic cfg_write;
  logic start_wr_one;
  logic start_wr_zero;
  logic trigger_hit;
  logic timer_single;
  logic is_single;
  logic store_result;
  logic start_pulse;
  logic stop_pulse;
  logic [CHAN_W-1:0] channel_next;
  logic [DATA_W-1:0] conv_mode_view;
  logic [DATA_W-1:0] trig_mode_view;
  logic [DATA_W-1:0] ref_ctrl_view;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign wr_mode = wr_en && (addr == OFS_CONV_MODE);
  assign wr_trig = wr_en && (addr == OFS_TRIG_MODE);
  assign wr_chan = wr_en && (addr == OFS_CHAN_SEL);
  assign wr_port = wr_en && (addr == OFS_PORT_CFG);
  assign wr_ref = wr_en && (addr == OFS_REF_CTRL);

  // mode, channel or port writes beat a simultaneous conversion end
  assign cfg_write = wr_mode || wr_chan || wr_port; // R25

  assign start_wr_one = wr_mode && wdata[BIT_CONV_START]; // R1
  assign start_wr_zero = wr_mode && !wdata[BIT_CONV_START];

  // ----------------------------------------------------------------
  // trigger qualification
  // ----------------------------------------------------------------
  assign trigger_hit = timer_trig_enable_reg && timer_trig[trig_source_sel_reg]; // R9 R10
  assign is_single = (single_continuous_sel_reg == MODE_SINGLE);
  assign timer_single = timer_trig_enable_reg && is_single;

  assign channel_next = wr_chan ? wdata[CHAN_MSB:0] : channel_field_reg; // R20

  assign store_result = sar_bus.done && !cfg_write; // R2 R25

  // ----------------------------------------------------------------
  // start / abort decision
  // ----------------------------------------------------------------
  always_comb begin
    start_pulse = 1'b0;
    stop_pulse = 1'b0;
    if (trigger_hit) begin
      // trigger set wins over a coinciding stop
      start_pulse = 1'b1; // R10 R11
    end else if (start_wr_zero) begin
      stop_pulse = 1'b1; // R8 R12
    end else if (start_wr_one) begin
      start_pulse = 1'b1; // R1 R5
    end else if (wr_chan && sar_bus.busy && !timer_single) begin
      start_pulse = 1'b1; // R6
    end else if (sar_bus.done && conv_start_bit_reg && !is_single) begin
      start_pulse = 1'b1; // R3
    end
  end

  assign sar_bus.start = start_pulse;
  assign sar_bus.stop = stop_pulse;
  assign sar_bus.step_cycles = STEP_BASE_CYCLES + {3'h0, conv_time_sel_reg};

  // ----------------------------------------------------------------
  // conversion start bit
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      conv_start_bit_reg <= 1'b0;
    end else if (trigger_hit) begin
      conv_start_bit_reg <= 1'b1; // R10
    end else if (wr_mode) begin
      conv_start_bit_reg <= wdata[BIT_CONV_START]; // R1 R8
    end else if (sar_bus.done && is_single) begin
      conv_start_bit_reg <= 1'b0; // R4
    end
  end

  // ----------------------------------------------------------------
  // converter mode register fields
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      single_continuous_sel_reg <= 1'b0;
      conv_time_sel_reg <= '0;
      comparator_enable_reg <= 1'b0;
    end else if (wr_mode) begin
      single_continuous_sel_reg <= wdata[BIT_SINGLE_CONT]; // R19
      conv_time_sel_reg <= wdata[CTS_MSB:CTS_LSB]; // R19
      comparator_enable_reg <= wdata[BIT_CMP_EN]; // R21
    end
  end

  // ----------------------------------------------------------------
  // trigger mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_trig_enable_reg <= 1'b0;
      trig_source_sel_reg <= 1'b0;
    end else if (wr_trig) begin
      trig_source_sel_reg <= wdata[BIT_TRIG_SRC]; // R18
      // timer mode is left only while no conversion is enabled
      if (wdata[BIT_TIMER_EN] || !conv_start_bit_reg) begin
        timer_trig_enable_reg <= wdata[BIT_TIMER_EN]; // R9 R13 R18
      end
    end
  end

  // ----------------------------------------------------------------
  // channel selection
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      channel_field_reg <= '0;
    end else if (wr_chan) begin
      channel_field_reg <= wdata[CHAN_MSB:0]; // R20
    end
  end

  // the converting channel only changes when a conversion starts
  always_ff @(posedge clock) begin
    if (reset) begin
      chan_active_reg <= '0;
    end else if (start_pulse) begin
      chan_active_reg <= channel_next; // R1 R6 R7
    end
  end

  // ----------------------------------------------------------------
  // port and reference configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      port_analog_cfg_reg <= '0;
    end else if (wr_port) begin
      port_analog_cfg_reg <= wdata[PORT_CFG_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ref_source_sel_reg <= 1'b0;
      booster_enable_reg <= 1'b0;
    end else if (wr_ref) begin
      ref_source_sel_reg <= wdata[BIT_REF_SRC];
      booster_enable_reg <= wdata[BIT_BOOSTER];
    end
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  // old value is sampled into read data on the same edge
  always_ff @(posedge clock) begin
    if (reset) begin
      result_wide_reg <= RES_WIDE_RST; // R23
      result_narrow_reg <= RES_NARROW_RST; // R23
    end else if (store_result) begin
      result_wide_reg <= {4'h0, sar_bus.result}; // R2 R24
      result_narrow_reg <= sar_bus.result[RES_W-1:NARROW_LSB]; // R26
    end
  end

  // ----------------------------------------------------------------
  // conversion end request
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      conv_end_irq_reg <= 1'b0;
    end else begin
      conv_end_irq_reg <= store_result; // R2 R25
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  assign conv_mode_view = {conv_start_bit_reg, single_continuous_sel_reg,
                           conv_time_sel_reg, comparator_enable_reg};
  assign trig_mode_view = {timer_trig_enable_reg, 6'h00, trig_source_sel_reg};
  assign ref_ctrl_view = {ref_source_sel_reg, 5'h00, booster_enable_reg, 1'b0};

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_reg <= REG_RST;
    end else if (rd_en) begin
      unique case (addr)
        OFS_CONV_MODE: begin
          rdata_reg <= conv_mode_view;
        end
        OFS_TRIG_MODE: begin
          rdata_reg <= trig_mode_view;
        end
        OFS_CHAN_SEL: begin
          rdata_reg <= {4'h0, channel_field_reg};
        end
        OFS_RES_WIDE_LO: begin
          rdata_reg <= result_wide_reg[DATA_W-1:0]; // R24
        end
        OFS_RES_WIDE_HI: begin
          rdata_reg <= result_wide_reg[WIDE_W-1:DATA_W]; // R24
        end
        OFS_RES_NARROW: begin
          rdata_reg <= result_narrow_reg; // R24
        end
        OFS_PORT_CFG: begin
          rdata_reg <= {3'h0, port_analog_cfg_reg};
        end
        OFS_REF_CTRL: begin
          rdata_reg <= ref_ctrl_view;
        end
      endcase
    end else begin
      rdata_reg <= REG_RST;
    end
  end

  // ----------------------------------------------------------------
  // approximation engine
  // ----------------------------------------------------------------
  adcts_sar u_sar (
    .clock(clock),
    .reset(reset),
    .comp_in(comp_in),
    .sar(sar_bus)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = rdata_reg;
  assign conv_end_irq = conv_end_irq_reg;
  assign chan_active = chan_active_reg;
  assign sample_hold = sar_bus.sampling;
  assign tap_code = sar_bus.trial;
  assign comparator_enable = comparator_enable_reg;
  assign booster_enable = booster_enable_reg;
  assign ref_source_sel = ref_source_sel_reg;
  assign conv_time_sel = conv_time_sel_reg;
  assign port_analog_cfg = port_analog_cfg_reg;

endmodule // adcts_top

// file: adcts_pkg.sv
package adcts_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 12;
  localparam int WIDE_W = 16;
  localparam int CHAN_W = 4;
  localparam int CTS_W = 5;
  localparam int PORT_CFG_W = 5;
  localparam int CNT_W = 8;
  localparam int BIT_IDX_W = 4;
  localparam int TRIG_W = 2;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONV_MODE = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_TRIG_MODE = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CHAN_SEL = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_RES_WIDE_LO = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_RES_WIDE_HI = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_RES_NARROW = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_PORT_CFG = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_REF_CTRL = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_CONV_START = 7;
  localparam int BIT_SINGLE_CONT = 6;
  localparam int CTS_MSB = 5;
  localparam int CTS_LSB = 1;
  localparam int BIT_CMP_EN = 0;
  localparam int BIT_TIMER_EN = 7;
  localparam int BIT_TRIG_SRC = 0;
  localparam int CHAN_MSB = 3;
  localparam int BIT_REF_SRC = 7;
  localparam int BIT_BOOSTER = 1;
  localparam int NARROW_LSB = 4;
  localparam logic MODE_SINGLE = 1'b1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [WIDE_W-1:0] RES_WIDE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RES_NARROW_RST = 8'h00;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SAMPLE_TIME_NS = 500;
  localparam int SAMPLE_CYCLES_I = (SAMPLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [CNT_W-1:0] SAMPLE_CYCLES = CNT_W'(SAMPLE_CYCLES_I);
  localparam logic [CNT_W-1:0] STEP_BASE_CYCLES = 8'h04;
  localparam logic [BIT_IDX_W-1:0] MSB_IDX = 4'hb;

endpackage

// file: adcts_sar_if.sv
`timescale 1ns/10ps
interface adcts_sar_if;
  import adcts_pkg::*;
  logic start;
  logic stop;
  logic [CNT_W-1:0] step_cycles;
  logic busy;
  logic sampling;
  logic done;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] trial;

  modport ctrl (output start, output stop, output step_cycles,
                input busy, input sampling, input done, input result, input trial);
  modport engine (input start, input stop, input step_cycles,
                  output busy, output sampling, output done, output result, output trial);
endinterface : adcts_sar_if

// file: adcts_sar.sv
`timescale 1ns/10ps
module adcts_sar
  import adcts_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic comp_in,
  adcts_sar_if.engine sar
);

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcts_state_e;

  adcts_state_e state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [BIT_IDX_W-1:0] bit_idx_reg;
  logic [RES_W-1:0] approx_shift_reg;
  logic [RES_W-1:0] result_reg;
  logic done_reg;
  logic step_end;

  assign step_end = (cnt_reg == sar.step_cycles - 8'h01);

  // ----------------------------------------------------------------
  // sequencing: start always restarts from sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset || sar.stop) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      bit_idx_reg <= MSB_IDX;
      approx_shift_reg <= RES_RST;
    end else if (sar.start) begin
      state_reg <= ST_SAMPLE;
      cnt_reg <= '0;
      bit_idx_reg <= MSB_IDX;
      approx_shift_reg <= RES_RST;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
        end
        ST_SAMPLE: begin
          if (cnt_reg == SAMPLE_CYCLES - 8'h01) begin
            state_reg <= ST_CONVERT;
            cnt_reg <= '0;
            approx_shift_reg[MSB_IDX] <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        ST_CONVERT: begin
          if (step_end) begin
            cnt_reg <= '0;
            approx_shift_reg[bit_idx_reg] <= comp_in;
            if (bit_idx_reg == '0) begin
              state_reg <= ST_IDLE;
            end else begin
              bit_idx_reg <= bit_idx_reg - 4'h1;
              approx_shift_reg[bit_idx_reg - 4'h1] <= 1'b1;
            end
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // completion
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      done_reg <= 1'b0;
      result_reg <= RES_RST;
    end else begin
      done_reg <= 1'b0;
      if (!sar.stop && !sar.start && state_reg == ST_CONVERT && step_end
          && bit_idx_reg == '0) begin
        done_reg <= 1'b1;
        result_reg <= {approx_shift_reg[RES_W-1:1], comp_in};
      end
    end
  end

  assign sar.busy = (state_reg != ST_IDLE);
  assign sar.sampling = (state_reg == ST_SAMPLE);
  assign sar.done = done_reg;
  assign sar.result = result_reg;
  assign sar.trial = approx_shift_reg;

endmodule // adcts_sar

// file: adcts_top_assertions.sv
`timescale 1ns/10ps
module adcts_chk
  import adcts_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [TRIG_W-1:0] timer_trig,
  input wire logic conv_end_irq,
  input wire logic [CHAN_W-1:0] chan_active,
  input wire logic sample_hold,
  input wire logic comparator_enable,
  input wire logic [CTS_W-1:0] conv_time_sel
);
  // ----
  // shadow of written registers and phase counters
  // ----
  logic [DATA_W-1:0] mode_reg, trig_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic [9:0] low_cnt_reg, hold_cnt_reg;
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_reg <= 8'h00;
      trig_reg <= 8'h00;
      chan_reg <= 4'h0;
    end else if (wr_en) begin
      if (addr == OFS_CONV_MODE) mode_reg <= wdata;
      if (addr == OFS_TRIG_MODE) trig_reg <= wdata;
      if (addr == OFS_CHAN_SEL) chan_reg <= wdata[CHAN_MSB:0];
    end
  end
  always_ff @(posedge clock) begin
    if (reset || sample_hold) low_cnt_reg <= 10'h000;
    else if (low_cnt_reg != 10'h3ff) low_cnt_reg <= low_cnt_reg + 10'h001;
  end
  // restart events reopen the sampling count
  always_ff @(posedge clock) begin
    if (reset || !sample_hold || timer_trig != 2'h0
      || wr_en && !(addr == OFS_CHAN_SEL && trig_reg[7] && mode_reg[6])) hold_cnt_reg <= 10'h000;
    else hold_cnt_reg <= hold_cnt_reg + 10'h001;
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_irq_pulse: assert property (conv_end_irq |=> !conv_end_irq)
    else $error("irq longer than one cycle");
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_trig_start: assert property (trig_reg[7] && timer_trig[trig_reg[0]] && !wr_en |=> sample_hold)
    else $error("trigger did not start sampling");
  a_trig_off: assert property (!trig_reg[7] && timer_trig != 2'h0 && !wr_en && !sample_hold
    && !conv_end_irq |=> !sample_hold) else $error("trigger started in software mode");
  a_stop_now: assert property (wr_en && addr == OFS_CONV_MODE && !wdata[7]
    && timer_trig == 2'h0 |=> (!sample_hold && !conv_end_irq) [*4])
    else $error("stop not immediate");
  a_cfg_drop: assert property (wr_en && (addr == OFS_CONV_MODE || addr == OFS_CHAN_SEL
    || addr == OFS_PORT_CFG) |=> !conv_end_irq) else $error("irq after config write");
  a_cont_restart: assert property (conv_end_irq && !mode_reg[6] && !wr_en |=> sample_hold)
    else $error("continuous mode did not restart");
  a_single_idle: assert property (conv_end_irq && mode_reg[6] && !wr_en && timer_trig == 2'h0
    |=> !sample_hold [*4]) else $error("single mode restarted");
  a_cfg_mirror: assert property (wr_en && addr == OFS_CONV_MODE |=> comparator_enable ==
    $past(wdata[0]) && conv_time_sel == $past(wdata[5:1])) else $error("mode outputs wrong");
  a_chan_latch: assert property ($rose(sample_hold) |-> chan_active == chan_reg)
    else $error("wrong channel latched");
  a_hold_len: assert property ($fell(sample_hold) && !$past(wr_en)
    |-> hold_cnt_reg == 10'(SAMPLE_CYCLES)) else $error("sampling length wrong");
  a_step_time: assert property (conv_end_irq
    |-> low_cnt_reg == 10'(12 * (int'(STEP_BASE_CYCLES) + int'(conv_time_sel)) + 1))
    else $error("step phase length wrong");
  c_cont: cover property (conv_end_irq && !mode_reg[6]);
  c_timer: cover property (trig_reg[7] && timer_trig != 2'h0);
  c_abort: cover property ($fell(sample_hold) && $past(wr_en));
endmodule // adcts_chk
bind adcts_top adcts_chk u_adcts_chk (.clock, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata,
  .timer_trig, .conv_end_irq, .chan_active, .sample_hold, .comparator_enable, .conv_time_sel);

// file: adcts_analog_model.sv
`timescale 1ns/10ps
module adcts_analog_model
  import adcts_pkg::*;
(
  input wire logic clock,
  input wire logic sample_hold,
  input wire logic [CHAN_W-1:0] chan_active,
  input wire logic [RES_W-1:0] tap_code,
  output logic comp_in
);
  // ----
  // held input level, one fixed level per channel
  // ----
  logic [RES_W-1:0] held_reg;
  always_ff @(posedge clock) begin
    if (sample_hold) held_reg <= 12'h123 + 12'(chan_active) * 12'h0f1;
  end
  assign comp_in = (held_reg >= tap_code);
endmodule // adcts_analog_model

// file: adcts_top_test.sv
`timescale 1ns/10ps
module adcts_top_test;
  import adcts_pkg::*;
  localparam int CONV = SAMPLE_CYCLES_I + 1 + 12 * int'(STEP_BASE_CYCLES);
  logic clock, reset, wr_en, rd_en, comp_in, conv_end_irq, sample_hold;
  logic comparator_enable, booster_enable, ref_source_sel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rv;
  logic [TRIG_W-1:0] timer_trig;
  logic [CHAN_W-1:0] chan_active;
  logic [RES_W-1:0] tap_code;
  logic [CTS_W-1:0] conv_time_sel;
  logic [PORT_CFG_W-1:0] port_analog_cfg;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int t_go, t_irq, t0;
  adcts_top u_adcts_top (.clock, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .timer_trig,
    .comp_in, .conv_end_irq, .chan_active, .sample_hold, .tap_code, .comparator_enable,
    .booster_enable, .ref_source_sel, .conv_time_sel, .port_analog_cfg);
  adcts_analog_model u_adcts_analog_model (.clock, .sample_hold, .chan_active, .tap_code,
    .comp_in);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  // ----
  // bus and check helpers
  // ----
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    #1 t_go = cyc + 1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic pulse(int i);
    @(posedge clock);
    timer_trig[i] <= 1'b1;
    #1 t_go = cyc + 1;
    @(posedge clock);
    timer_trig <= 2'h0;
  endtask
  task automatic wait_irq(int lim);
    int n = 0;
    t_irq = -1;
    while (n < lim && t_irq < 0) begin
      @(posedge clock);
      #1 n++;
      if (conv_end_irq === 1'b1) t_irq = cyc;
    end
  endtask
  function automatic logic [RES_W-1:0] lvl(int c);
    return 12'h123 + 12'(c) * 12'h0f1;
  endfunction
  task automatic res(logic [RES_W-1:0] e);
    logic [DATA_W-1:0] lo;
    rd(OFS_RES_WIDE_LO);
    lo = rv;
    rd(OFS_RES_WIDE_HI);
    chk("wide result", {rv, lo}, {4'h0, e});
    rd(OFS_RES_NARROW);
    chk("narrow result", 16'(rv), 16'(e[11:4]));
  endtask
  task automatic conv(int c, logic [DATA_W-1:0] m);
    wr(OFS_CHAN_SEL, 8'(c));
    wr(OFS_CONV_MODE, m);
    wait_irq(CONV + 400);
    chk("conv time", 16'(t_irq - t_go), 16'(CONV + 12 * int'(m[5:1])));
    res(lvl(c));
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    res(12'h000);
    wr(OFS_REF_CTRL, 8'h82);
    #1 chk("ref ctrl", {booster_enable, ref_source_sel}, 2'h3);
    repeat (2000) @(posedge clock);
    wr(OFS_CONV_MODE, 8'h4b);
    #1 chk("cmp enable", comparator_enable, 1'b1);
    rd(OFS_CONV_MODE);
    chk("mode reg", rv, 8'h4b);
    wr(OFS_TRIG_MODE, 8'hff);
    rd(OFS_TRIG_MODE);
    chk("trigger reg", rv, 8'h81);
    wr(OFS_CHAN_SEL, 8'hfa);
    rd(OFS_CHAN_SEL);
    chk("channel reg", rv, 8'h0a);
    wr(OFS_RES_NARROW, 8'h5a);
    res(12'h000);
    wr(OFS_TRIG_MODE, 8'h00);
    repeat (200) @(posedge clock);
  endtask
  task automatic t_soft;
    conv(3, 8'hcb);
    rd(OFS_CONV_MODE);
    chk("start cleared", rv, 8'h4b);
    wait_irq(CONV);
    chk("single idle", 16'(t_irq), 16'hffff);
    conv(5, 8'h81);
    t_go = t_irq;
    wait_irq(CONV + 20);
    chk("cont period", 16'(t_irq - t_go), 16'(CONV));
    repeat (30) @(posedge clock);
    wr(OFS_CONV_MODE, 8'h01);
    wait_irq(CONV + 20);
    chk("stopped", 16'(t_irq), 16'hffff);
    res(lvl(5));
  endtask
  task automatic t_abort;
    wr(OFS_CHAN_SEL, 8'h02);
    wr(OFS_CONV_MODE, 8'hc1);
    repeat (120) @(posedge clock);
    wr(OFS_CONV_MODE, 8'hc1);
    res(lvl(5));
    wait_irq(CONV + 20);
    chk("restart time", 16'(t_irq - t_go), 16'(CONV));
    res(lvl(2));
    wr(OFS_CONV_MODE, 8'hc1);
    repeat (50) @(posedge clock);
    wr(OFS_CHAN_SEL, 8'h07);
    t0 = t_go;
    res(lvl(2));
    wait_irq(CONV + 20);
    chk("chan restart", 16'(t_irq - t0), 16'(CONV));
    res(lvl(7));
  endtask
  task automatic t_timer;
    wr(OFS_CONV_MODE, 8'h41);
    wr(OFS_TRIG_MODE, 8'h81);
    wr(OFS_CHAN_SEL, 8'h04);
    pulse(0);
    wait_irq(CONV + 20);
    chk("other source", 16'(t_irq), 16'hffff);
    pulse(1);
    t0 = t_go;
    rd(OFS_CONV_MODE);
    chk("hw start bit", rv, 8'hc1);
    wr(OFS_CHAN_SEL, 8'h09);
    wait_irq(CONV + 20);
    chk("no chan abort", 16'(t_irq - t0), 16'(CONV));
    res(lvl(4));
    pulse(1);
    repeat (60) @(posedge clock);
    pulse(1);
    wait_irq(CONV + 20);
    chk("trig restart", 16'(t_irq - t_go), 16'(CONV));
    res(lvl(9));
    wr(OFS_CONV_MODE, 8'h01);
    pulse(1);
    repeat (60) @(posedge clock);
    wr(OFS_CONV_MODE, 8'h01);
    wait_irq(CONV + 20);
    chk("timer stop", 16'(t_irq), 16'hffff);
    pulse(1);
    wait_irq(CONV + 20);
    chk("next trigger", 16'(t_irq - t_go), 16'(CONV));
    wr(OFS_CONV_MODE, 8'h01);
    wr(OFS_TRIG_MODE, 8'h00);
    pulse(1);
    wait_irq(CONV + 20);
    chk("software mode", 16'(t_irq), 16'hffff);
  endtask
  task automatic t_clash;
    conv(1, 8'hc1);
    wr(OFS_CHAN_SEL, 8'h06);
    wr(OFS_CONV_MODE, 8'hc1);
    repeat (CONV - 2) @(posedge clock);
    rd(OFS_RES_NARROW);
    chk("read first", 16'(rv), 16'(lvl(1) >> 4));
    chk("irq after read", conv_end_irq, 1'b1);
    res(lvl(6));
    wr(OFS_CHAN_SEL, 8'h0b);
    wr(OFS_CONV_MODE, 8'hc1);
    repeat (CONV - 2) @(posedge clock);
    wr(OFS_PORT_CFG, 8'h15);
    #1 chk("irq dropped", conv_end_irq, 1'b0);
    chk("port cfg", port_analog_cfg, 5'h15);
    res(lvl(6));
    wr(OFS_CONV_MODE, 8'h00);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    fail_count++;
    summarize;
  end
  initial begin
    reset = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    timer_trig = 2'h0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_soft;
    t_abort;
    t_timer;
    t_clash;
    summarize;
  end
endmodule // adcts_top_test
